// [common/tct_pkg.sv]
// package: constants, types and helpers for the conversion and thermostat block
`default_nettype none

package tct_pkg;

  // ---------------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned CONV_TIME_9B_US   = 93750;  // 93.75 ms at 9 bits
  localparam int unsigned CONV_9B_CYCLES    = CONV_TIME_9B_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned NV_WRITE_TYP_MS   = 4;
  localparam int unsigned NV_WRITE_MAX_MS   = 10;
  localparam int unsigned NV_WRITE_CYCLES   = NV_WRITE_TYP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned NV_WRITE_MAX_CYC  = NV_WRITE_MAX_MS * 1000000 / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------------
  // configuration register field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned CFG_DONE_BIT  = 7;
  localparam int unsigned CFG_HIGH_BIT  = 6;
  localparam int unsigned CFG_LOW_BIT   = 5;
  localparam int unsigned CFG_NVB_BIT   = 4;
  localparam int unsigned CFG_RES_HI    = 3;
  localparam int unsigned CFG_RES_LO    = 2;
  localparam int unsigned CFG_POL_BIT   = 1;
  localparam int unsigned CFG_SINGLE_BIT = 0;

  // ---------------------------------------------------------------------------
  // reset and factory values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] TEMP_RESET      = 16'hc400;
  localparam logic [15:0] UPPER_FACTORY   = 16'h0f00;
  localparam logic [15:0] LOWER_FACTORY   = 16'h0a00;
  localparam logic [1:0]  RES_RESET       = 2'h3;
  localparam logic        POL_FACTORY     = 1'b0;
  localparam logic        SINGLE_FACTORY  = 1'b0;

  // ---------------------------------------------------------------------------
  // commands and carriers
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_BEGIN_CONV,
    OP_HALT_CONV,
    OP_READ_TEMP,
    OP_UPPER_TRIP_ACCESS,
    OP_LOWER_TRIP_ACCESS,
    OP_CONFIG_ACCESS
  } tct_op_t;

  typedef struct packed {
    logic        write;
    tct_op_t     op;
    logic [15:0] wdata;
  } tct_cmd_t;

  // keeps the active upper bits for resolution select 0..3 (9..12 bits)
  function automatic logic [15:0] tct_res_mask(input logic [1:0] res);
    tct_res_mask = 16'hff80 | ((16'h0070 << (3 - 32'(res))) & 16'h0070);
  endfunction

endpackage

`default_nettype wire

// [hw/tct_core.sv]
// conversion sequencing, result formatting, thermostat and command port
//
// Functional notes
// - nonvolatile write keeps memory busy for its programming time, at most 10 ms.
// - without auto-start, stay idle after power-up until begin-conversion command.
// - with auto-start, convert right after power-up in the stored mode.
// - continuous mode repeats conversions until halt; begin restarts them.
// - one-shot mode: each begin command given while idle gives exactly one conversion, then idle.
// - resolution 9 to 12 bits selectable, 12 bits after power-up.
// - conversion time doubles for each extra bit of resolution.
// - each completed conversion stores a 16-bit two's complement result.
// - result bits 3..0 zero; unused low bits zero per resolution.
// - read-temperature command returns the result; result is read-only.
// - result holds minus sixty degrees until first conversion completes.
// - trip points are 16-bit signed, nonvolatile, factory 15 and 10 degrees.
// - configuration: six volatile upper bits, two nonvolatile low bits.
// - thermostat state updates only when a conversion completes; a polarity write taken while memory is free flips the output one clock later.
// - output active at result >= upper, inactive once result < lower.
// - output active level follows the polarity bit.
// - trip points masked to the selected resolution on read and compare.
// - trip points reached only by their access commands; kept as storage.
// - high and low flags are sticky until written zero or power cycles.
// - both resolution select bits are one at power-up, meaning 12 bits.
// - done bit reads zero during a conversion and one when finished.
// - nonvolatile busy bit reads one during a nonvolatile write.
`timescale 1ns/1ps
`default_nettype none

module tct_core #(
  parameter bit          AUTO_START  = 1'b0,
  parameter int unsigned CONV_9B_CYC = tct_pkg::CONV_9B_CYCLES,
  parameter int unsigned NV_WR_CYC   = tct_pkg::NV_WRITE_CYCLES
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             link_clk,
  input  wire logic             cmd_valid,
  input  wire tct_pkg::tct_cmd_t cmd,
  output logic                  cmd_ready,
  output logic                  rsp_valid,
  output logic [15:0]           rsp_data,
  input  wire logic [15:0]      sensor_code,
  output logic                  thermo_output
);
  import tct_pkg::*;

  typedef enum logic {
    ST_IDLE,
    ST_CONV
  } tct_state_t;

  // ---------------------------------------------------------------------------
  // link side: hold a command and toggle a request across
  // ---------------------------------------------------------------------------
  tct_cmd_t    cmd_hold_reg;
  logic        req_tog_reg;
  logic        link_busy_reg;
  logic        ack_s1_reg;
  logic        ack_s2_reg;
  logic        ack_s3_reg;
  logic        rsp_valid_reg;
  logic [15:0] rsp_data_reg;
  logic        ack_tog_reg;
  logic [15:0] core_rdata_reg;

  assign cmd_ready = ~link_busy_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_data  = rsp_data_reg;

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      cmd_hold_reg  <= '0;
      req_tog_reg   <= 1'b0;
      link_busy_reg <= 1'b0;
    end else if (cmd_valid && !link_busy_reg) begin
      cmd_hold_reg  <= cmd;
      req_tog_reg   <= ~req_tog_reg;
      link_busy_reg <= 1'b1;
    end else if (ack_s2_reg != ack_s3_reg) begin
      link_busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      ack_s3_reg <= 1'b0;
    end else begin
      ack_s1_reg <= ack_tog_reg;
      ack_s2_reg <= ack_s1_reg;
      ack_s3_reg <= ack_s2_reg;
    end
  end

  // core answer word is held steady until the next request, so it may be sampled here
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= '0;
    end else begin
      rsp_valid_reg <= (ack_s2_reg != ack_s3_reg);
      if (ack_s2_reg != ack_s3_reg) begin
        rsp_data_reg <= core_rdata_reg;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // core side: request detection
  // ---------------------------------------------------------------------------
  logic req_s1_reg;
  logic req_s2_reg;
  logic req_s3_reg;
  logic req_new;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
    end else begin
      req_s1_reg <= req_tog_reg;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
    end
  end

  assign req_new = (req_s2_reg != req_s3_reg);

  logic do_begin;
  logic do_halt;
  logic wr_upper;
  logic wr_lower;
  logic wr_cfg;

  assign do_begin = req_new && (cmd_hold_reg.op == OP_BEGIN_CONV);
  assign do_halt  = req_new && (cmd_hold_reg.op == OP_HALT_CONV);
  assign wr_upper = req_new && cmd_hold_reg.write && (cmd_hold_reg.op == OP_UPPER_TRIP_ACCESS);
  assign wr_lower = req_new && cmd_hold_reg.write && (cmd_hold_reg.op == OP_LOWER_TRIP_ACCESS);
  assign wr_cfg   = req_new && cmd_hold_reg.write && (cmd_hold_reg.op == OP_CONFIG_ACCESS);

  // ---------------------------------------------------------------------------
  // configuration and nonvolatile storage
  // ---------------------------------------------------------------------------
  logic [1:0]  res_reg;
  logic        pol_reg;
  logic        single_reg;
  logic [15:0] upper_trip_point_reg;
  logic [15:0] lower_trip_point_reg;
  logic        nv_busy_reg;
  logic [31:0] nv_cnt_reg;
  logic        nv_start;
  logic [15:0] mask;

  assign mask     = tct_res_mask(res_reg);
  assign nv_start = !nv_busy_reg && (wr_upper || wr_lower || wr_cfg);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      res_reg <= RES_RESET;
    end else if (wr_cfg) begin
      res_reg <= cmd_hold_reg.wdata[CFG_RES_HI:CFG_RES_LO];
    end
  end

  // nonvolatile words change only when the memory is free
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      upper_trip_point_reg <= UPPER_FACTORY;
      lower_trip_point_reg <= LOWER_FACTORY;
      pol_reg              <= POL_FACTORY;
      single_reg           <= SINGLE_FACTORY;
    end else if (nv_start) begin
      if (wr_upper) begin
        upper_trip_point_reg <= cmd_hold_reg.wdata;
      end
      if (wr_lower) begin
        lower_trip_point_reg <= cmd_hold_reg.wdata;
      end
      if (wr_cfg) begin
        pol_reg    <= cmd_hold_reg.wdata[CFG_POL_BIT];
        single_reg <= cmd_hold_reg.wdata[CFG_SINGLE_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      nv_busy_reg <= 1'b0;
      nv_cnt_reg  <= '0;
    end else if (nv_start) begin
      nv_busy_reg <= 1'b1;
      nv_cnt_reg  <= '0;
    end else if (nv_busy_reg) begin
      if (nv_cnt_reg == NV_WR_CYC - 1) begin
        nv_busy_reg <= 1'b0;
      end
      nv_cnt_reg <= nv_cnt_reg + 32'h1;
    end
  end

  // ---------------------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------------------
  tct_state_t  state_reg;
  logic        cont_run_reg;
  logic        boot_start_reg;
  logic [31:0] conv_cnt_reg;
  logic        conv_done;
  logic        go;

  assign conv_done = (state_reg == ST_CONV) && (conv_cnt_reg == (CONV_9B_CYC << res_reg) - 1);
  assign go        = do_begin || boot_start_reg;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      boot_start_reg <= AUTO_START;
    end else if (state_reg == ST_IDLE) begin
      boot_start_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg    <= ST_IDLE;
      cont_run_reg <= 1'b0;
      conv_cnt_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          conv_cnt_reg <= '0;
          if (go) begin
            state_reg    <= ST_CONV;
            cont_run_reg <= ~single_reg;
          end
        end
        ST_CONV: begin
          if (do_halt) begin
            cont_run_reg <= 1'b0;
          end else if (do_begin && !single_reg) begin
            cont_run_reg <= 1'b1;
          end
          if (conv_done) begin
            conv_cnt_reg <= '0;
            if (!cont_run_reg || do_halt || single_reg) begin
              state_reg <= ST_IDLE;
            end
          end else begin
            conv_cnt_reg <= conv_cnt_reg + 32'h1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // result, thermostat and flags
  // ---------------------------------------------------------------------------
  logic [15:0] temp_reg;
  logic [15:0] sample_masked;
  logic [15:0] upper_masked;
  logic [15:0] lower_masked;
  logic        hit_upper;
  logic        above_upper;
  logic        below_lower;
  logic        active_reg;
  logic        active_next;
  logic        high_seen_flag_reg;
  logic        low_seen_flag_reg;
  logic        thermo_output_reg;

  assign sample_masked = sensor_code & mask;
  assign upper_masked  = upper_trip_point_reg & mask;
  assign lower_masked  = lower_trip_point_reg & mask;
  assign hit_upper     = $signed(sample_masked) >= $signed(upper_masked);
  assign above_upper   = $signed(sample_masked) > $signed(upper_masked);
  assign below_lower   = $signed(sample_masked) < $signed(lower_masked);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      temp_reg <= TEMP_RESET;
    end else if (conv_done) begin
      temp_reg <= sample_masked;
    end
  end

  always_comb begin
    active_next = active_reg;
    if (conv_done) begin
      if (hit_upper) begin
        active_next = 1'b1;
      end else if (below_lower) begin
        active_next = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= active_next;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      thermo_output_reg <= ~POL_FACTORY;
    end else begin
      thermo_output_reg <= pol_reg ? active_next : ~active_next;
    end
  end

  assign thermo_output = thermo_output_reg;

  // a set from a completing conversion wins over a same-cycle clear
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      high_seen_flag_reg <= 1'b0;
      low_seen_flag_reg  <= 1'b0;
    end else begin
      if (conv_done && above_upper) begin
        high_seen_flag_reg <= 1'b1;
      end else if (wr_cfg && !cmd_hold_reg.wdata[CFG_HIGH_BIT]) begin
        high_seen_flag_reg <= 1'b0;
      end
      if (conv_done && below_lower) begin
        low_seen_flag_reg <= 1'b1;
      end else if (wr_cfg && !cmd_hold_reg.wdata[CFG_LOW_BIT]) begin
        low_seen_flag_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // answer word
  // ---------------------------------------------------------------------------
  logic [7:0] cfg_view;

  always_comb begin
    cfg_view                 = '0;
    cfg_view[CFG_DONE_BIT]   = (state_reg != ST_CONV);
    cfg_view[CFG_HIGH_BIT]   = high_seen_flag_reg;
    cfg_view[CFG_LOW_BIT]    = low_seen_flag_reg;
    cfg_view[CFG_NVB_BIT]    = nv_busy_reg;
    cfg_view[CFG_RES_HI:CFG_RES_LO] = res_reg;
    cfg_view[CFG_POL_BIT]    = pol_reg;
    cfg_view[CFG_SINGLE_BIT] = single_reg;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ack_tog_reg    <= 1'b0;
      core_rdata_reg <= '0;
    end else if (req_new) begin
      ack_tog_reg <= ~ack_tog_reg;
      if (cmd_hold_reg.write) begin
        core_rdata_reg <= '0;
      end else begin
        case (cmd_hold_reg.op)
          OP_READ_TEMP:         core_rdata_reg <= temp_reg;
          OP_UPPER_TRIP_ACCESS: core_rdata_reg <= upper_masked;
          OP_LOWER_TRIP_ACCESS: core_rdata_reg <= lower_masked;
          OP_CONFIG_ACCESS:     core_rdata_reg <= {8'h00, cfg_view};
          default:              core_rdata_reg <= '0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  sequence conv_finishes;
    conv_done;
  endsequence

  sequence back_to_idle;
    ##1 (state_reg == ST_IDLE);
  endsequence

  nv_busy_bound_a: assert property (@(posedge sys_clk) disable iff (reset)
    nv_busy_reg |-> (nv_cnt_reg < NV_WR_CYC) && (NV_WR_CYC <= NV_WRITE_MAX_CYC))
    else $error("nonvolatile busy outlasts its write time");

  idle_wait_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_reg == ST_IDLE && !go) |=> (state_reg == ST_IDLE))
    else $error("conversion started without a begin command");

  single_shot_a: assert property (@(posedge sys_clk) disable iff (reset)
    (conv_finishes and single_reg) |-> back_to_idle)
    else $error("one-shot conversion did not return to idle");

  cont_repeat_a: assert property (@(posedge sys_clk) disable iff (reset)
    (conv_finishes and cont_run_reg && !single_reg && !do_halt) |=> (state_reg == ST_CONV))
    else $error("continuous conversion did not repeat");

  result_zeros_a: assert property (@(posedge sys_clk) disable iff (reset)
    conv_finishes |=> (temp_reg[3:0] == 4'h0) && ((temp_reg & ~$past(mask)) == 16'h0000))
    else $error("result low bits not cleared");

  thermo_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    !conv_done |=> $stable(active_reg))
    else $error("thermostat changed without a completed conversion");

  thermo_trip_a: assert property (@(posedge sys_clk) disable iff (reset)
    (conv_done && hit_upper) |=> active_reg ##0 (thermo_output == pol_reg))
    else $error("thermostat not active at or above upper trip point");

  thermo_level_a: assert property (@(posedge sys_clk) disable iff (reset)
    $stable(pol_reg) |-> (thermo_output == (pol_reg ? active_reg : ~active_reg)))
    else $error("thermostat level does not follow polarity");

  flag_sticky_a: assert property (@(posedge sys_clk) disable iff (reset)
    (high_seen_flag_reg && !wr_cfg) |=> high_seen_flag_reg)
    else $error("high flag dropped without a clearing write");

  done_status_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_reg == ST_CONV) |-> !cfg_view[CFG_DONE_BIT])
    else $error("done bit set during a conversion");

endmodule

`default_nettype wire

// [tb/tct_host_model.sv]
// host model: offers commands on the link port and collects the answers
`timescale 1ns/1ps
`default_nettype none
module tct_host_model
  import tct_pkg::*;
(
  input  wire logic              link_clk,
  input  wire logic              cmd_ready,
  input  wire logic              rsp_valid,
  input  wire logic [15:0]       rsp_data,
  output logic                   cmd_valid,
  output tct_pkg::tct_cmd_t      cmd
);
  import tct_pkg::*;
  int slow = 0;
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // each register has its own access op, the model never aliases them
  task automatic run(input logic wr, input tct_op_t opc, input logic [15:0] wd,
                     output logic [15:0] rd, output bit ok);
    logic rdy;
    rd = 16'hxxxx;
    ok = 1'b0;
    rdy = 1'b0;
    repeat (slow) @(posedge link_clk);
    @(posedge link_clk);
    #1;
    cmd_valid = 1'b1;
    cmd = '{write: wr, op: opc, wdata: wd};
    for (int i = 0; i < 64 && !rdy; i++) begin
      rdy = cmd_ready;
      @(posedge link_clk);
      #1;
    end
    cmd_valid = 1'b0;
    // released lines stop showing the old value
    cmd = ~cmd;
    for (int i = 0; i < 64 && !ok; i++) begin
      if (rsp_valid === 1'b1) begin
        rd = rsp_data;
        ok = 1'b1;
      end else begin
        @(posedge link_clk);
        #1;
      end
    end
  endtask
endmodule
`default_nettype wire

// [tb/tb_tct_core.sv]
// testbench: conversion, result, trip point and thermostat checks
`timescale 1ns/1ps
`default_nettype none
module tb_tct_core;
  import tct_pkg::*;
  localparam int unsigned CONV9 = 8;
  localparam int unsigned NVWR  = 16;
  logic        sys_clk     = 1'b0;
  logic        link_clk    = 1'b0;
  logic        reset       = 1'b1;
  logic [15:0] sensor_code = 16'h2000;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        rsp_valid;
  logic        thermo_output;
  logic        auto_thermo;
  logic [15:0] rsp_data;
  tct_cmd_t    cmd;
  int          fails       = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  always #5 sys_clk = ~sys_clk;
  always #6 link_clk = ~link_clk;
  tct_core #(.AUTO_START(1'b0), .CONV_9B_CYC(CONV9), .NV_WR_CYC(NVWR)) tct_core_inst (
    .sys_clk(sys_clk), .reset(reset), .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .sensor_code(sensor_code),
    .thermo_output(thermo_output));
  tct_core #(.AUTO_START(1'b1), .CONV_9B_CYC(CONV9), .NV_WR_CYC(NVWR)) tct_core_auto_inst (
    .sys_clk(sys_clk), .reset(reset), .link_clk(link_clk), .cmd_valid(1'b0), .cmd('0),
    .cmd_ready(), .rsp_valid(), .rsp_data(), .sensor_code(sensor_code), .thermo_output(auto_thermo));
  tct_host_model tct_host_model_inst (
    .link_clk(link_clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .cmd_valid(cmd_valid), .cmd(cmd));
  // ----
  // helpers
  // ----
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic xfer(input logic wr, input tct_op_t opc, input logic [15:0] wd, output logic [15:0] rd);
    bit ok;
    tct_host_model_inst.run(wr, opc, wd, rd, ok);
    check("answer", {15'h0, ok}, 16'h0001);
  endtask
  task automatic wsys(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic set_sensor(input logic [15:0] v);
    wsys(1);
    sensor_code = v;
  endtask
  task automatic wait_done();
    logic [15:0] rd;
    rd = '0;
    for (int i = 0; i < 40 && rd[7] !== 1'b1; i++) xfer(1'b0, OP_CONFIG_ACCESS, 16'h0, rd);
    check("done bit", rd & 16'h0080, 16'h0080);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end
  // ----
  // scenarios
  // ----
  task automatic t_power_up();
    logic [15:0] rd;
    tct_op_t     ops[4];
    logic [15:0] vals[4];
    ops = '{OP_READ_TEMP, OP_UPPER_TRIP_ACCESS, OP_LOWER_TRIP_ACCESS, OP_CONFIG_ACCESS};
    vals = '{16'hc400, 16'h0f00, 16'h0a00, 16'h008c};
    wsys(100);
    check("idle output", {15'h0, thermo_output}, 16'h0001);
    check("auto output", {15'h0, auto_thermo}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, ops[i], 16'h0, rd);
      check("power-up value", rd, vals[i]);
    end
    xfer(1'b1, OP_READ_TEMP, 16'h1234, rd);
    xfer(1'b0, OP_READ_TEMP, 16'h0, rd);
    check("result read-only", rd, 16'hc400);
  endtask
  task automatic t_one_shot();
    logic [15:0] rd;
    set_sensor(16'h1917);
    xfer(1'b1, OP_CONFIG_ACCESS, 16'h000d, rd);
    xfer(1'b0, OP_CONFIG_ACCESS, 16'h0, rd);
    check("busy while writing", rd & 16'h0010, 16'h0010);
    wsys(NVWR + 4);
    xfer(1'b0, OP_CONFIG_ACCESS, 16'h0, rd);
    check("config after write", rd, 16'h008d);
    xfer(1'b1, OP_BEGIN_CONV, 16'h0, rd);
    xfer(1'b0, OP_CONFIG_ACCESS, 16'h0, rd);
    check("done while converting", rd & 16'h0080, 16'h0000);
    wait_done();
    xfer(1'b0, OP_READ_TEMP, 16'h0, rd);
    check("one-shot result", rd, 16'h1910);
    set_sensor(16'hf5e7);
    wsys(200);
    xfer(1'b0, OP_READ_TEMP, 16'h0, rd);
    check("single conversion only", rd, 16'h1910);
    check("output after one-shot", {15'h0, thermo_output}, 16'h0000);
    xfer(1'b1, OP_BEGIN_CONV, 16'h0, rd);
    wait_done();
    xfer(1'b0, OP_READ_TEMP, 16'h0, rd);
    check("negative result", rd, 16'hf5e0);
  endtask
  task automatic t_resolution();
    logic [15:0] rd;
    logic [15:0] mask;
    set_sensor(16'h1fff);
    for (int r = 0; r < 4; r++) begin
      mask = 16'hfff0 << (3 - r);
      xfer(1'b1, OP_CONFIG_ACCESS, 16'(4 * r + 1), rd);
      wsys(NVWR + 4);
      xfer(1'b1, OP_UPPER_TRIP_ACCESS, 16'h0fff, rd);
      wsys(NVWR + 4);
      xfer(1'b0, OP_UPPER_TRIP_ACCESS, 16'h0, rd);
      check("upper masked", rd, 16'h0fff & mask);
      xfer(1'b1, OP_BEGIN_CONV, 16'h0, rd);
      wait_done();
      xfer(1'b0, OP_READ_TEMP, 16'h0, rd);
      check("result masked", rd, 16'h1fff & mask);
    end
  endtask
  task automatic t_thermostat();
    logic [15:0] rd;
    logic [15:0] codes[5];
    logic [15:0] outs[5];
    logic [15:0] flg[5];
    codes = '{16'h0c00, 16'h09f0, 16'h0a00, 16'h0f00, 16'h0f10};
    outs = '{16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0000};
    flg = '{16'h0000, 16'h0020, 16'h0020, 16'h0020, 16'h0060};
    // trip points are written here while the core is idle, before conversions begin
    xfer(1'b1, OP_UPPER_TRIP_ACCESS, 16'h0f00, rd);
    wsys(NVWR + 4);
    xfer(1'b1, OP_LOWER_TRIP_ACCESS, 16'h0a00, rd);
    wsys(NVWR + 4);
    xfer(1'b1, OP_CONFIG_ACCESS, 16'h000c, rd);
    wsys(NVWR + 4);
    xfer(1'b1, OP_BEGIN_CONV, 16'h0, rd);
    for (int i = 0; i < 5; i++) begin
      set_sensor(codes[i]);
      wsys(150);
      check("thermostat", {15'h0, thermo_output}, outs[i]);
      xfer(1'b0, OP_CONFIG_ACCESS, 16'h0, rd);
      check("flags", rd & 16'h0060, flg[i]);
    end
    tct_host_model_inst.slow = 2;
    xfer(1'b1, OP_CONFIG_ACCESS, 16'h000e, rd);
    wsys(4);
    check("polarity high", {15'h0, thermo_output}, 16'h0001);
    xfer(1'b1, OP_HALT_CONV, 16'h0, rd);
    wsys(80);
    set_sensor(16'h0100);
    wsys(200);
    xfer(1'b0, OP_READ_TEMP, 16'h0, rd);
    check("halted result", rd, 16'h0f10);
    check("held output", {15'h0, thermo_output}, 16'h0001);
    xfer(1'b1, OP_CONFIG_ACCESS, 16'h000e, rd);
    xfer(1'b0, OP_CONFIG_ACCESS, 16'h0, rd);
    check("flags cleared", rd & 16'h0060, 16'h0000);
    xfer(1'b1, OP_BEGIN_CONV, 16'h0, rd);
    wsys(150);
    xfer(1'b0, OP_READ_TEMP, 16'h0, rd);
    check("restarted result", rd, 16'h0100);
    check("output released", {15'h0, thermo_output}, 16'h0000);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (10) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    t_power_up();
    t_one_shot();
    t_resolution();
    t_thermostat();
    test_done();
  end
endmodule
`default_nettype wire
